//--- rtl/tof_temp_offset_top.sv
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
// Contract
// [R1] Remote-1 readings get the signed remote-1 offset added, quarter degree per count
// [R2] Local readings get the signed local offset added, quarter degree per count
// [R3] Remote-2 readings get the signed remote-2 offset added, quarter degree per count
// [R4] After lock is set, remote-1 and local offset writes are ignored
// [R5] Reset clears all three offsets and configuration register two
// [R6] Config bit 0: fan 1 pulse input, or two-wire sensing when one
// [R7] Config bit 1: fan 2 pulse input, or two-wire sensing when one
// [R8] Config bit 2: fan 3 pulse input, or two-wire sensing when one
// [R9] Config bit 3: fan 4 pulse input, or two-wire sensing when one
// [R10] Two-wire sensing compares against the separate threshold register
// [R11] Config bit 4 set turns averaging off, single samples reported
// [R12] Corrected temperature is stored and used downstream for limits and fans
module tof_temp_offset_top #(
  parameter int AVG_LOG2 = tof_pkg::AVG_LOG2
) (
  input  wire logic                              clk_sys_in,
  input  wire logic                              rst_n_in,
  input  wire logic                              wb_cyc_in,
  input  wire logic                              wb_stb_in,
  input  wire logic                              wb_we_in,
  input  wire logic [tof_pkg::ADR_W-1:0]         wb_adr_in,
  input  wire logic [3:0]                        wb_sel_in,
  input  wire logic [31:0]                       wb_dat_in,
  output logic      [31:0]                       wb_dat_out,
  output logic                                   wb_ack_out,
  input  wire tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] raw_temp_in,
  input  wire logic [tof_pkg::NUM_FAN-1:0]       fan_speed_pulse_in,
  input  wire logic [tof_pkg::NUM_FAN-1:0][7:0]  fan_sense_level_in,
  output logic      [tof_pkg::NUM_FAN-1:0]       fan_pulse_out,
  output logic      [tof_pkg::NUM_FAN-1:0]       fan_two_wire_select_out,
  output logic                                   averaging_off_out,
  output logic      [7:0]                        fan_sense_threshold_out,
  output logic                                   cfg_locked_out,
  output tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] corr_temp_out
);

  ////////////////////////////////////////////////////////////
  // Reset release

  logic rst_meta_ff;
  logic rst_sync_ff;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////
  // Register state

  logic [7:0]                             rem1_ofs_ff;
  logic [7:0]                             local_ofs_ff;
  logic [7:0]                             rem2_ofs_ff;
  logic [tof_pkg::NUM_CH-1:0][7:0]        ofs_all;
  logic [7:0]                             cfg_two_ff;
  logic [7:0]                             thresh_ff;
  logic                                   lock_ff;
  logic [tof_pkg::NUM_CH-1:0][tof_pkg::TEMP_W-1:0] rd_temp_ff;
  logic                                   ack_ff;
  logic [31:0]                            rd_dat_ff;
  logic [31:0]                            nxt_rd_dat;
  logic [7:0]                             bus_idx;
  logic                                   bus_req;
  logic                                   bus_wr;
  logic                                   bus_rd;
  logic                                   wr_rem1;
  logic                                   wr_local;
  logic                                   wr_rem2;
  logic                                   wr_cfg;
  logic                                   wr_thresh;
  logic                                   wr_lock;

  ////////////////////////////////////////////////////////////
  // Bus decode

  function automatic logic reg_wr(input logic       wr,
                                  input logic [7:0] idx,
                                  input logic [7:0] want);
    return wr && (idx == want);
  endfunction

  assign bus_idx = wb_adr_in[tof_pkg::IDX_LSB +: 8];
  assign bus_req = wb_cyc_in && wb_stb_in && !ack_ff;
  assign bus_wr  = bus_req && wb_we_in && wb_sel_in[0];
  assign bus_rd  = bus_req && !wb_we_in;

  ////////////////////////////////////////////////////////////
  // Per-register write strobes

  // [R4] Offset strobes, remote-1 and local locked, remote-2 not
  assign wr_rem1   = reg_wr(bus_wr, bus_idx, tof_pkg::IDX_REM1_OFS);
  assign wr_local  = reg_wr(bus_wr, bus_idx, tof_pkg::IDX_LOCAL_OFS);
  assign wr_rem2   = reg_wr(bus_wr, bus_idx, tof_pkg::IDX_REM2_OFS);
  // [R6] [R11] Configuration strobe
  assign wr_cfg    = reg_wr(bus_wr, bus_idx, tof_pkg::IDX_CFG_TWO);
  // [R10] Threshold strobe
  assign wr_thresh = reg_wr(bus_wr, bus_idx, tof_pkg::IDX_THRESH);
  // [R4] Lock register strobe
  assign wr_lock   = reg_wr(bus_wr, bus_idx, tof_pkg::IDX_LOCK);

  ////////////////////////////////////////////////////////////
  // Acknowledge, one cycle after the strobe, dropped after one cycle

  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= bus_req;
    end
  end

  ////////////////////////////////////////////////////////////
  // Offset registers, each one its own variable

  // [R4] Lock blocks write
  // [R5] Offset cleared
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rem1_ofs_ff <= tof_pkg::RST_OFS;
    end else if (wr_rem1 && !lock_ff) begin
      rem1_ofs_ff <= wb_dat_in[7:0];
    end
  end

  // [R4] Lock blocks write
  // [R5] Offset cleared
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      local_ofs_ff <= tof_pkg::RST_OFS;
    end else if (wr_local && !lock_ff) begin
      local_ofs_ff <= wb_dat_in[7:0];
    end
  end

  // Remote-2 offset stays writable under lock
  // [R5] Offset cleared
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rem2_ofs_ff <= tof_pkg::RST_OFS;
    end else if (wr_rem2) begin
      rem2_ofs_ff <= wb_dat_in[7:0];
    end
  end

  ////////////////////////////////////////////////////////////
  // Offsets gathered per channel for the adders

  always_comb begin
    ofs_all                    = '0;
    ofs_all[tof_pkg::CH_REM1]  = rem1_ofs_ff;
    ofs_all[tof_pkg::CH_LOCAL] = local_ofs_ff;
    ofs_all[tof_pkg::CH_REM2]  = rem2_ofs_ff;
  end

  ////////////////////////////////////////////////////////////
  // Configuration, threshold and lock

  // [R5] Config cleared
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      cfg_two_ff <= tof_pkg::RST_CFG;
    end else if (wr_cfg) begin
      cfg_two_ff <= wb_dat_in[7:0];
    end
  end

  // [R10] Threshold register store
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      thresh_ff <= tof_pkg::RST_THRESH;
    end else if (wr_thresh) begin
      thresh_ff <= wb_dat_in[7:0];
    end
  end

  // [R4] Lock sets once
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      lock_ff <= 1'b0;
    end else if (wr_lock && wb_dat_in[tof_pkg::LOCK_BIT]) begin
      lock_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////
  // Read data

  // [R12] Readings and registers read back
  always_comb begin
    nxt_rd_dat = 32'h0000_0000;
    case (bus_idx)
      tof_pkg::IDX_REM1_OFS: begin
        nxt_rd_dat[7:0] = rem1_ofs_ff;
      end
      tof_pkg::IDX_LOCAL_OFS: begin
        nxt_rd_dat[7:0] = local_ofs_ff;
      end
      tof_pkg::IDX_REM2_OFS: begin
        nxt_rd_dat[7:0] = rem2_ofs_ff;
      end
      tof_pkg::IDX_CFG_TWO: begin
        nxt_rd_dat[7:0] = cfg_two_ff;
      end
      tof_pkg::IDX_THRESH: begin
        nxt_rd_dat[7:0] = thresh_ff;
      end
      tof_pkg::IDX_LOCK: begin
        nxt_rd_dat[tof_pkg::LOCK_BIT] = lock_ff;
      end
      tof_pkg::IDX_RD_REM1: begin
        nxt_rd_dat[tof_pkg::TEMP_W-1:0] = rd_temp_ff[tof_pkg::CH_REM1];
      end
      tof_pkg::IDX_RD_LOCAL: begin
        nxt_rd_dat[tof_pkg::TEMP_W-1:0] = rd_temp_ff[tof_pkg::CH_LOCAL];
      end
      tof_pkg::IDX_RD_REM2: begin
        nxt_rd_dat[tof_pkg::TEMP_W-1:0] = rd_temp_ff[tof_pkg::CH_REM2];
      end
      default: begin
        nxt_rd_dat = 32'h0000_0000;
      end
    endcase
  end

  // Read word held until the next read is taken
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_dat_ff <= 32'h0000_0000;
    end else if (bus_rd) begin
      rd_dat_ff <= nxt_rd_dat;
    end
  end

  ////////////////////////////////////////////////////////////
  // Temperature path: averaging, then offset correction

  tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] avg_smp;
  tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] corr_smp;
  tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] corr_out_ff;

  for (genvar c = 0; c < tof_pkg::NUM_CH; c++) begin : g_ch
    // [R11] Averaging off select
    tof_avg #(
      .LOG2       (AVG_LOG2)
    ) u_avg (
      .clk_in     (clk_sys_in),
      .rst_n_in   (rst_sync_ff),
      .avg_off_in (cfg_two_ff[tof_pkg::CFG_AVG_BIT]),
      .smp_in     (raw_temp_in[c]),
      .smp_out    (avg_smp[c])
    );

    // [R1] [R2] [R3] Offset added per channel
    tof_ofs_add u_ofs (
      .clk_in     (clk_sys_in),
      .rst_n_in   (rst_sync_ff),
      .ofs_in     (ofs_all[c]),
      .smp_in     (avg_smp[c]),
      .smp_out    (corr_smp[c])
    );
  end

  // [R12] Corrected reading stored
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      rd_temp_ff <= '{default: tof_pkg::RST_TEMP};
    end else begin
      for (int c = 0; c < tof_pkg::NUM_CH; c++) begin
        if (corr_smp[c].vld) begin
          rd_temp_ff[c] <= corr_smp[c].val;
        end
      end
    end
  end

  // [R12] Corrected sample passed on
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      corr_out_ff <= '0;
    end else begin
      for (int c = 0; c < tof_pkg::NUM_CH; c++) begin
        corr_out_ff[c].vld <= corr_smp[c].vld;
        if (corr_smp[c].vld) begin
          corr_out_ff[c].val <= corr_smp[c].val;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Fan speed sense selection

  logic [tof_pkg::NUM_FAN-1:0] fan_pulse_ff;
  logic [tof_pkg::NUM_FAN-1:0] fan_sel;
  logic [tof_pkg::NUM_FAN-1:0] fan_level_hit;

  // [R6] [R7] [R8] [R9] Per fan select
  assign fan_sel = cfg_two_ff[tof_pkg::CFG_FAN_LSB +: tof_pkg::NUM_FAN];

  // [R10] Threshold comparison
  always_comb begin
    fan_level_hit = '0;
    for (int f = 0; f < tof_pkg::NUM_FAN; f++) begin
      fan_level_hit[f] = (fan_sense_level_in[f] > thresh_ff);
    end
  end

  // [R10] Two-wire or pulse routing
  always_ff @(posedge clk_sys_in or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      fan_pulse_ff <= '0;
    end else begin
      for (int f = 0; f < tof_pkg::NUM_FAN; f++) begin
        if (fan_sel[f]) begin
          fan_pulse_ff[f] <= fan_level_hit[f];
        end else begin
          fan_pulse_ff[f] <= fan_speed_pulse_in[f];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_out              = ack_ff;
  assign wb_dat_out              = rd_dat_ff;
  assign fan_pulse_out           = fan_pulse_ff;
  assign fan_two_wire_select_out = fan_sel;
  assign averaging_off_out       = cfg_two_ff[tof_pkg::CFG_AVG_BIT];
  assign fan_sense_threshold_out = thresh_ff;
  assign cfg_locked_out          = lock_ff;
  assign corr_temp_out           = corr_out_ff;

endmodule

//--- include/tof_pkg.sv
package tof_pkg;

  ////////////////////////////////////////////////////////////
  // Widths and counts
  localparam int TEMP_W   = 10;
  localparam int OFS_W    = 8;
  localparam int NUM_CH   = 3;
  localparam int NUM_FAN  = 4;
  localparam int AVG_LOG2 = 2;
  localparam int ADR_W    = 10;
  localparam int IDX_LSB  = 2;

  ////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [7:0] IDX_REM1_OFS  = 8'h70;
  localparam logic [7:0] IDX_LOCAL_OFS = 8'h71;
  localparam logic [7:0] IDX_REM2_OFS  = 8'h72;
  localparam logic [7:0] IDX_CFG_TWO   = 8'h73;
  localparam logic [7:0] IDX_THRESH    = 8'h7d;
  localparam logic [7:0] IDX_LOCK      = 8'h40;
  localparam logic [7:0] IDX_RD_REM1   = 8'h80;
  localparam logic [7:0] IDX_RD_LOCAL  = 8'h81;
  localparam logic [7:0] IDX_RD_REM2   = 8'h82;

  ////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [7:0]        RST_OFS    = 8'h00;
  localparam logic [7:0]        RST_CFG    = 8'h00;
  localparam logic [7:0]        RST_THRESH = 8'h00;
  localparam logic [TEMP_W-1:0] RST_TEMP   = 10'h000;

  ////////////////////////////////////////////////////////////
  // Field positions
  localparam int CFG_FAN_LSB = 0;
  localparam int CFG_AVG_BIT = 4;
  localparam int LOCK_BIT    = 0;
  localparam int CH_REM1     = 0;
  localparam int CH_LOCAL    = 1;
  localparam int CH_REM2     = 2;

  ////////////////////////////////////////////////////////////
  // Temperature sample, quarter degree per count
  typedef struct packed {
    logic                     vld;
    logic signed [TEMP_W-1:0] val;
  } tof_temp_t;

endpackage

//--- rtl/tof_avg.sv
`timescale 1ns/1ps
module tof_avg #(
  parameter int LOG2 = tof_pkg::AVG_LOG2
) (
  input  wire logic              clk_in,
  input  wire logic              rst_n_in,
  input  wire logic              avg_off_in,
  input  wire tof_pkg::tof_temp_t smp_in,
  output tof_pkg::tof_temp_t     smp_out
);

  localparam int AW = tof_pkg::TEMP_W + LOG2;

  logic signed [AW-1:0] acc_ff;
  logic [LOG2-1:0]      cnt_ff;
  logic signed [AW-1:0] ext;
  logic signed [AW-1:0] sum;
  logic signed [AW-1:0] mean;

  assign ext  = AW'(smp_in.val);
  assign sum  = acc_ff + ext;
  assign mean = sum >>> LOG2;

  ////////////////////////////////////////////////////////////
  // Averaging over a block of samples, or single samples
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_ff  <= '0;
      cnt_ff  <= '0;
      smp_out <= '0;
    end else begin
      smp_out.vld <= 1'b0;
      if (avg_off_in) begin
        acc_ff <= '0;
        cnt_ff <= '0;
        if (smp_in.vld) begin
          smp_out <= smp_in;
        end
      end else if (smp_in.vld) begin
        cnt_ff <= cnt_ff + 1'b1;
        if (&cnt_ff) begin
          acc_ff      <= '0;
          smp_out.vld <= 1'b1;
          smp_out.val <= mean[tof_pkg::TEMP_W-1:0];
        end else begin
          acc_ff <= sum;
        end
      end
    end
  end

endmodule

//--- rtl/tof_ofs_add.sv
`timescale 1ns/1ps
module tof_ofs_add (
  input  wire logic                     clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic [tof_pkg::OFS_W-1:0] ofs_in,
  input  wire tof_pkg::tof_temp_t       smp_in,
  output tof_pkg::tof_temp_t            smp_out
);

  localparam int SW = tof_pkg::TEMP_W + 1;

  logic signed [SW-1:0] sum;

  assign sum = SW'(smp_in.val) + SW'($signed(ofs_in));

  function automatic logic [tof_pkg::TEMP_W-1:0] sat(input logic signed [SW-1:0] s);
    logic [tof_pkg::TEMP_W-1:0] r;
    r = s[tof_pkg::TEMP_W-1:0];
    if (s[SW-1] != s[SW-2]) begin
      r = {s[SW-1], {(tof_pkg::TEMP_W-1){~s[SW-1]}}};
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////
  // Signed offset added, clamped to the reading range
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      smp_out <= '0;
    end else begin
      smp_out.vld <= smp_in.vld;
      if (smp_in.vld) begin
        smp_out.val <= sat(sum);
      end
    end
  end

endmodule

//--- tb/tof_far_model.sv
`timescale 1ns/1ps
module tof_far_model (
  input  wire logic                                clk_in,
  output tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] temp_out,
  output logic [tof_pkg::NUM_FAN-1:0]              pulse_out,
  output logic [tof_pkg::NUM_FAN-1:0][7:0]         level_out
);
  initial begin
    temp_out  = '0;
    pulse_out = '0;
    level_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // One-cycle sample; value then shows its inverse so stale data is not reused
  task automatic send(input int ch, input int v);
    @(posedge clk_in);
    temp_out[ch].vld <= 1'b1;
    temp_out[ch].val <= 10'(v);
    @(posedge clk_in);
    temp_out[ch].vld <= 1'b0;
    temp_out[ch].val <= ~10'(v);
  endtask

  // Fan pulse lines and two-wire sense level
  task automatic fan(input logic [3:0] t, input logic [7:0] l);
    @(posedge clk_in);
    pulse_out <= t;
    level_out <= {4{l}};
  endtask
endmodule

//--- tb/tof_asserts.sv
`timescale 1ns/1ps
module tof_asserts #(
  parameter int AVG_LOG2 = 2
) (
  input wire logic                                clk_sys_in,
  input wire logic                                rst_n_in,
  input wire logic                                wb_cyc_in,
  input wire logic                                wb_stb_in,
  input wire logic                                wb_we_in,
  input wire logic [tof_pkg::ADR_W-1:0]           wb_adr_in,
  input wire logic [3:0]                          wb_sel_in,
  input wire logic [31:0]                         wb_dat_in,
  input wire logic [31:0]                         wb_dat_out,
  input wire logic                                wb_ack_out,
  input wire tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] raw_temp_in,
  input wire logic [tof_pkg::NUM_FAN-1:0]         fan_speed_pulse_in,
  input wire logic [tof_pkg::NUM_FAN-1:0][7:0]    fan_sense_level_in,
  input wire logic [tof_pkg::NUM_FAN-1:0]         fan_pulse_out,
  input wire logic [tof_pkg::NUM_FAN-1:0]         fan_two_wire_select_out,
  input wire logic                                averaging_off_out,
  input wire logic [7:0]                          fan_sense_threshold_out,
  input wire logic                                cfg_locked_out,
  input wire tof_pkg::tof_temp_t [tof_pkg::NUM_CH-1:0] corr_temp_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_take;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence s_cfg_wr;
    s_take ##0 (wb_we_in && wb_sel_in[0] && wb_adr_in[9:2] == tof_pkg::IDX_CFG_TWO);
  endsequence
  sequence s_fast_smp;
    (raw_temp_in[0].vld && averaging_off_out) ##1 averaging_off_out [*2];
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  ack_answer_a: assert property (s_take |=> wb_ack_out)
    else $error("request not acked");
  read_hold_a: assert property ($changed(wb_dat_out) |-> wb_ack_out)
    else $error("read data moved without ack");
  lock_sticky_a: assert property (cfg_locked_out |=> cfg_locked_out)
    else $error("lock cleared");
  lock_cause_a: assert property ($rose(cfg_locked_out)
    |-> $past(wb_we_in) || $past(wb_we_in, 2))
    else $error("lock set without write");
  select_mirror_a: assert property (s_cfg_wr
    |-> ##2 fan_two_wire_select_out == $past(wb_dat_in[3:0], 2))
    else $error("two-wire select differs from write");
  avg_mirror_a: assert property (s_cfg_wr
    |-> ##2 averaging_off_out == $past(wb_dat_in[4], 2))
    else $error("averaging flag differs from write");
  fan_route_a: assert property ($stable(fan_two_wire_select_out) && $stable(fan_sense_threshold_out)
    |=> fan_pulse_out[0] == ($past(fan_two_wire_select_out[0]) ?
      ($past(fan_sense_level_in[0]) > $past(fan_sense_threshold_out)) : $past(fan_speed_pulse_in[0])))
    else $error("fan pulse routing wrong");
  corr_latency_a: assert property (s_fast_smp |=> corr_temp_out[0].vld)
    else $error("corrected sample late");
endmodule

bind tof_temp_offset_top tof_asserts #(.AVG_LOG2(AVG_LOG2)) u_tof_asserts (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
  .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in),
  .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .raw_temp_in(raw_temp_in),
  .fan_speed_pulse_in(fan_speed_pulse_in), .fan_sense_level_in(fan_sense_level_in),
  .fan_pulse_out(fan_pulse_out), .fan_two_wire_select_out(fan_two_wire_select_out),
  .averaging_off_out(averaging_off_out), .fan_sense_threshold_out(fan_sense_threshold_out),
  .cfg_locked_out(cfg_locked_out), .corr_temp_out(corr_temp_out));

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic                                   clk = 1'b0;
  logic                                   rst_n;
  logic                                   cyc;
  logic                                   stb;
  logic                                   we;
  logic [9:0]                             adr;
  logic [3:0]                             sel;
  logic [31:0]                            wdat;
  logic [31:0]                            rdat;
  logic                                   ack;
  tof_pkg::tof_temp_t [2:0]               raw;
  tof_pkg::tof_temp_t [2:0]               corr;
  logic [3:0]                             fan_speed_pulse;
  logic [3:0][7:0]                        lvl;
  logic [3:0]                             pulse;
  logic [3:0]                             two_wire;
  logic                                   avg_off;
  logic [7:0]                             thr;
  logic                                   locked;
  logic [31:0]                            q;
  logic [7:0]                             idxs [9] = '{8'h70, 8'h71, 8'h72, 8'h73, 8'h7d,
                                                       8'h40, 8'h80, 8'h81, 8'h82};
  int                                     num_errors = 0;
  int                                     checks = 0;
  int                                     cycles = 0;

  always #12.5 clk = ~clk;

  tof_temp_offset_top #(.AVG_LOG2(1)) u_tof_temp_offset_top (
    .clk_sys_in(clk), .rst_n_in(rst_n), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .raw_temp_in(raw), .fan_speed_pulse_in(fan_speed_pulse), .fan_sense_level_in(lvl),
    .fan_pulse_out(pulse), .fan_two_wire_select_out(two_wire), .averaging_off_out(avg_off),
    .fan_sense_threshold_out(thr), .cfg_locked_out(locked), .corr_temp_out(corr));

  tof_far_model u_tof_far_model (.clk_in(clk), .temp_out(raw), .pulse_out(fan_speed_pulse), .level_out(lvl));

  ////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Classic single bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic s0);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel  <= {3'h0, s0};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      tally_and_finish();
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 1'b1);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    wb(1'b0, idx, 8'h00, 1'b1);
    chk(q, e);
  endtask

  function automatic int sat(input int v);
    return (v > 511) ? 511 : ((v < -512) ? -512 : v);
  endfunction

  // Send one or two samples, compare the corrected output and reading register
  task automatic temp(input int ch, input int a, input int b, input int ofs, input int navg);
    int n;
    int e;
    e = sat(((navg == 1) ? a : ((a + b) >>> 1)) + ofs);
    u_tof_far_model.send(ch, a);
    if (navg == 2) u_tof_far_model.send(ch, b);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (corr[ch].vld !== 1'b1 && n < 20);
    chk(32'(corr[ch].vld), 32'h1);
    chk({22'h0, corr[ch].val}, {22'h0, 10'(e)});
    rd(8'(tof_pkg::IDX_RD_REM1 + ch), {22'h0, 10'(e)});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    cyc   = 1'b0;
    stb   = 1'b0;
    we    = 1'b0;
    adr   = '0;
    sel   = '0;
    wdat  = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    foreach (idxs[i]) rd(idxs[i], 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h10, 8'h5a);
    rd(8'h10, 32'h0);
    wr(8'h70, 8'h05);
    wr(8'h71, 8'hfc);
    wr(8'h72, 8'h7f);
    wb(1'b1, 8'h70, 8'haa, 1'b0);
    rd(8'h70, 32'h05);
    rd(8'h71, 32'hfc);
    rd(8'h72, 32'h7f);
    wr(8'h73, 8'hff);
    rd(8'h73, 32'hff);
    chk(32'(avg_off), 32'h1);
    chk(32'(two_wire), 32'hf);
    wr(8'h73, 8'h10);
    temp(0, 100, 0, 5, 1);
    temp(1, -3, 0, -4, 1);
    temp(2, 496, 0, 127, 1);
    wr(8'h72, 8'h80);
    temp(2, -500, 0, -128, 1);
    wr(8'h73, 8'h00);
    temp(0, 10, 21, 5, 2);
    temp(1, -3, -4, -4, 2);
    for (int i = 0; i < 2; i++) begin
      wr(8'h73, (i == 0) ? 8'h05 : 8'h0a);
      wr(8'h7d, 8'h80);
      chk(32'(thr), 32'h80);
      u_tof_far_model.fan(4'h0, 8'h81);
      repeat (3) @(posedge clk);
      chk(32'(pulse), (i == 0) ? 32'h5 : 32'ha);
      u_tof_far_model.fan(4'hf, 8'h80);
      repeat (3) @(posedge clk);
      chk(32'(pulse), (i == 0) ? 32'ha : 32'h5);
    end
    wr(8'h40, 8'h01);
    wr(8'h70, 8'h33);
    wr(8'h71, 8'h33);
    wr(8'h72, 8'h33);
    rd(8'h70, 32'h05);
    rd(8'h71, 32'hfc);
    rd(8'h72, 32'h33);
    wr(8'h40, 8'h00);
    @(posedge clk);
    chk(32'(locked), 32'h1);
    tally_and_finish();
  end
endmodule
